// ### common/angle_mon_pkg.sv
`default_nettype none
package angle_mon_pkg;
  // Clock rate.
  localparam int unsigned CLK_HZ            = 125_000_000;
  // Time constants in their own units and the derived cycle and tick counts.
  localparam int unsigned TICK_MS           = 10;
  localparam int unsigned TICK_CYC_DFLT     = (CLK_HZ / 1000) * TICK_MS;
  localparam int unsigned CHAN_PERSIST_MS   = 100;
  localparam int unsigned CHAN_PERSIST_TICK = CHAN_PERSIST_MS / TICK_MS;
  // Analogue limits in mV, input samples are 13-bit millivolt codes.
  localparam logic [12:0] SHORT_GND_MV      = 13'h0064;
  localparam logic [12:0] SHORT_SUP_MV      = 13'h1324;
  localparam logic [12:0] RANGE_LO_MV       = 13'h01F4;
  localparam logic [12:0] RANGE_HI_MV       = 13'h1194;
  // Straight ahead sits in the middle of the range; also the sampler's reset value.
  localparam logic [12:0] CENTRE_MV         = 13'h09C4;
  // Parameter reset values and the redundant and analogue codes they are compared with.
  localparam logic [15:0] ENGAGE_LIMIT_RST  = 16'h0064;
  localparam logic [7:0]  REDUNDANT_RST     = 8'hFF;
  localparam logic [7:0]  REDUNDANT_YES     = 8'hFF;
  localparam logic [7:0]  IFTYPE_RST        = 8'h00;
  localparam logic [7:0]  IFTYPE_ANALOGUE   = 8'h00;
  localparam logic [15:0] CHAN_THR_RST      = 16'h0064;
  localparam logic [15:0] IPROC_THR_RST     = 16'h0064;
  localparam logic [7:0]  IPROC_TIME_RST    = 8'h0A;
  // APB register byte offsets.
  localparam logic [7:0]  OFS_CTRL          = 8'h00;
  localparam logic [7:0]  OFS_ENGAGE_LIMIT  = 8'h04;
  localparam logic [7:0]  OFS_SENSOR_CFG    = 8'h08;
  localparam logic [7:0]  OFS_CHAN_THR      = 8'h0C;
  localparam logic [7:0]  OFS_IPROC_CFG     = 8'h10;
  localparam logic [7:0]  OFS_STATUS        = 8'h14;
  localparam logic [7:0]  OFS_IRQ_STATUS    = 8'h18;
  localparam logic [7:0]  OFS_IRQ_MASK      = 8'h1C;
  localparam logic [7:0]  OFS_ANGLE         = 8'h20;
  // Event bit positions in status and mask.
  localparam int unsigned EV_SHORT_GND  = 0;
  localparam int unsigned EV_SHORT_SUP  = 1;
  localparam int unsigned EV_CHAN_DIV   = 2;
  localparam int unsigned EV_IPROC_DIV  = 3;
  localparam int unsigned EV_PLAUS      = 4;
  localparam int unsigned EV_SAFE       = 5;
  localparam int unsigned EV_ENGAGED    = 6;
  localparam int unsigned EV_RANGE      = 7;
  localparam int unsigned EV_W          = 8;
  // Engagement control states, Gray coded.
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_ARMED   = 2'b01,
    ST_ENGAGED = 2'b11,
    ST_SAFE    = 2'b10
  } eng_state_t;
endpackage
`default_nettype wire

// ### common/angle_if.sv
`timescale 1ns/1ps
`default_nettype none
// Scaled angles from both channels and their raw fault flags.
interface angle_if;
  logic [15:0] prim_scaled;  // Primary channel in internal units.
  logic [15:0] red_scaled;   // Redundant channel in internal units.
  logic        short_gnd;    // Primary or monitored redundant input below ground-short limit.
  logic        short_sup;    // Primary or monitored redundant input above supply-short limit.
  logic        out_range;    // Primary or monitored redundant input outside the working range.
  modport scaler (output prim_scaled, red_scaled, short_gnd, short_sup, out_range);
  modport monitor (input prim_scaled, red_scaled, short_gnd, short_sup, out_range);
endinterface
`default_nettype wire

// ### rtl/angle_scaler.sv
`timescale 1ns/1ps
`default_nettype none
// Input range check and scaling of both analogue channels.
module angle_scaler
  import angle_mon_pkg::*;
(
  input  wire logic pclk,           // System clock.
  input  wire logic presetn,        // Asynchronous reset, active low.
  input  wire logic [12:0] prim_mv, // Primary sample in mV, pin domain.
  input  wire logic [12:0] red_mv,  // Redundant sample in mV, pin domain.
  input  wire logic red_used,       // Redundant channel is monitored.
  angle_if.scaler   ang             // Scaled angles and flags.
);
  // ****************************************
  // Synchroniser and scaling state
  // ****************************************
  typedef struct packed {
    logic [12:0] p1, p2, p3, r1, r2, r3;
    logic [12:0] p_ok, r_ok;
    logic [15:0] ps, rs;
    logic        gnd, sup, rng;
  } sc_t;
  sc_t s_r, s_nxt;

  // Shorts and range limits for one sample.
  function automatic logic [2:0] chk(input logic [12:0] v);
    chk = {(v < RANGE_LO_MV) || (v > RANGE_HI_MV), v > SHORT_SUP_MV, v < SHORT_GND_MV};
  endfunction

  // Mid-range lands on zero; 1 mV maps to 1 internal unit. The redundant
  // sensor is inverted, so its scale is mirrored to match the primary.
  function automatic logic [15:0] scale(input logic [12:0] v, input logic inv);
    logic [15:0] d;
    d = {3'b000, v} - {3'b000, CENTRE_MV};
    scale = inv ? 16'h0000 - d : d;
  endfunction

  // Three-stage sampling; a new word is taken once stages two and three agree.
  always_comb begin
    logic [2:0] cp, cr;
    cp = 3'b000;
    cr = 3'b000;
    s_nxt = s_r;
    s_nxt.p1 = prim_mv;
    s_nxt.p2 = s_r.p1;
    s_nxt.p3 = s_r.p2;
    s_nxt.r1 = red_mv;
    s_nxt.r2 = s_r.r1;
    s_nxt.r3 = s_r.r2;
    if (s_r.p2 == s_r.p3) begin
      s_nxt.p_ok = s_r.p3;
    end
    if (s_r.r2 == s_r.r3) begin
      s_nxt.r_ok = s_r.r3;
    end
    cp = chk(s_r.p_ok);
    cr = red_used ? chk(s_r.r_ok) : 3'b000;
    s_nxt.gnd = cp[0] | cr[0];
    s_nxt.sup = cp[1] | cr[1];
    s_nxt.rng = cp[2] | cr[2];
    s_nxt.ps = scale(s_r.p_ok, 1'b0);
    s_nxt.rs = scale(s_r.r_ok, 1'b1);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Sampling stages start at mid-range; a zero here would read as a ground short.
      s_r      <= '0;
      s_r.p1   <= CENTRE_MV;
      s_r.p2   <= CENTRE_MV;
      s_r.p3   <= CENTRE_MV;
      s_r.p_ok <= CENTRE_MV;
      s_r.r1   <= CENTRE_MV;
      s_r.r2   <= CENTRE_MV;
      s_r.r3   <= CENTRE_MV;
      s_r.r_ok <= CENTRE_MV;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ang.prim_scaled = s_r.ps;
  assign ang.red_scaled  = s_r.rs;
  assign ang.short_gnd   = s_r.gnd;
  assign ang.short_sup   = s_r.sup;
  assign ang.out_range   = s_r.rng;
endmodule
`default_nettype wire

// ### rtl/angle_monitor.sv
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Engage only with engage flag set
// - Engage only when setpoint error within limit
// - Value 255 means redundant sensor fitted
// - Interface type zero selects analogue
// - Flag shorts below 100, above 4900 mV
// - Channel divergence over 100 ms trips safe
// - Scale inputs before comparing
// - Compare primary angle with peer processor
// - Peer divergence over time trips safe
// - Single sensor skips channel cross-check
// - Implausible movement forces safe state
module angle_monitor
  import angle_mon_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYC_DFLT  // Cycles per 10 ms step.
) (
  input  wire logic        pclk,            // APB clock, 125 MHz.
  input  wire logic        presetn,         // Asynchronous reset, active low.
  input  wire logic        psel,            // APB select.
  input  wire logic        penable,         // APB enable.
  input  wire logic        pwrite,          // APB direction.
  input  wire logic [7:0]  paddr,           // APB byte address.
  input  wire logic [31:0] pwdata,          // APB write data.
  output logic             pready,          // APB ready.
  output logic [31:0]      prdata,          // APB read data.
  output logic             pslverr,         // APB error on unmapped address.
  input  wire logic [12:0] prim_mv,         // Primary angle input, mV.
  input  wire logic [12:0] red_mv,          // Redundant angle input, mV.
  input  wire logic [15:0] peer_angle,      // Peer processor scaled angle.
  input  wire logic        engage_button,   // Engage button pulse, same clock.
  input  wire logic        engage_request,  // Closed-loop request level.
  input  wire logic [15:0] angle_setpoint,  // Set point, internal units.
  input  wire logic        plaus_fault,     // Plausibility algorithm mismatch.
  output logic             steer_engaged,   // Closed-loop steering active.
  output logic             safe_state,      // Safe state latched.
  output logic [15:0]      angle_out,       // Primary scaled angle to peer.
  output logic             irq              // Level interrupt.
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    eng_state_t  st;
    logic        eng_flag;
    logic [15:0] eng_lim;
    logic [7:0]  red_cfg;
    logic [7:0]  if_type;
    logic [15:0] chan_thr;
    logic [15:0] ip_thr;
    logic [7:0]  ip_time;
    logic [7:0]  irq_sts;
    logic [7:0]  irq_msk;
    logic [23:0] tick_cnt;
    logic [7:0]  chan_cnt;
    logic [7:0]  ip_cnt;
    logic [31:0] rdata;
    // Cycle counts of unbroken exceedance, used only by the timing checks.
    logic [31:0] chan_run;
    logic [31:0] ip_run;
  } mon_t;
  mon_t s_r, s_nxt;

  angle_if ang ();
  logic red_used;

  assign red_used = (s_r.red_cfg == REDUNDANT_YES);

  // Pin synchronisation, range checks and scaling sit in their own module.
  angle_scaler u_scaler (
    .pclk    (pclk),
    .presetn (presetn),
    .prim_mv (prim_mv),
    .red_mv  (red_mv),
    .red_used(red_used),
    .ang     (ang)
  );

  // Absolute difference of two signed internal-unit values.
  // The extra sign bit keeps a full-scale difference from wrapping.
  function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
    logic signed [16:0] d;
    d = $signed({a[15], a}) - $signed({b[15], b});
    absdiff = d[16] ? 16'(-d) : d[15:0];
  endfunction

  // ****************************************
  // Monitoring and engagement
  // ****************************************
  // Bus phases, exceedance flags and the events of this cycle.
  logic        acc, wr, rd, hit, tick, chan_ex, ip_ex, chan_trip, ip_trip, eng_ok;
  logic        analogue;
  logic [7:0]  ev;

  // All next-state logic of the monitor in one process.
  always_comb begin
    acc      = psel && penable;
    wr       = acc && pwrite;
    rd       = psel && !penable && !pwrite;
    analogue = (s_r.if_type == IFTYPE_ANALOGUE);
    // One tick per 10 ms step; both persistence timers count in ticks.
    tick     = (s_r.tick_cnt == 24'(TICK_CYC - 1));
    // no channel check with one sensor.
    chan_ex  = red_used && analogue &&
               (absdiff(ang.prim_scaled, ang.red_scaled) > s_r.chan_thr);
    ip_ex    = analogue && (absdiff(ang.prim_scaled, peer_angle) > s_r.ip_thr);
    chan_trip = chan_ex && (s_r.chan_cnt > 8'(CHAN_PERSIST_TICK));
    ip_trip   = ip_ex && (s_r.ip_cnt > s_r.ip_time);
    eng_ok   = absdiff(angle_setpoint, ang.prim_scaled) <= s_r.eng_lim;
    // Events of this cycle; each sets its sticky status bit.
    ev = '0;
    ev[EV_SHORT_GND] = analogue && ang.short_gnd;
    ev[EV_SHORT_SUP] = analogue && ang.short_sup;
    ev[EV_RANGE]     = analogue && ang.out_range;
    ev[EV_CHAN_DIV]  = chan_trip;
    ev[EV_IPROC_DIV] = ip_trip;
    ev[EV_PLAUS]     = plaus_fault;
    ev[EV_SAFE]      = (s_r.st != ST_SAFE) &&
                       (ev[EV_SHORT_GND] || ev[EV_SHORT_SUP] || chan_trip || ip_trip || plaus_fault);
    ev[EV_ENGAGED]   = 1'b0;

    s_nxt = s_r;
    s_nxt.tick_cnt = tick ? '0 : s_r.tick_cnt + 24'h000001;
    // Saturating counts cannot wrap below the limit and drop a standing trip.
    // timers restart on recovery.
    if (!chan_ex) begin
      s_nxt.chan_cnt = '0;
    end else if (tick && s_r.chan_cnt != 8'hFF) begin
      s_nxt.chan_cnt = s_r.chan_cnt + 8'h01;
    end

    if (!ip_ex) begin
      s_nxt.ip_cnt = '0;
    end else if (tick && s_r.ip_cnt != 8'hFF) begin
      s_nxt.ip_cnt = s_r.ip_cnt + 8'h01;
    end
    // Cycle counts of each unbroken exceedance, kept apart from the tick timers.
    s_nxt.chan_run = chan_ex ? s_r.chan_run + 32'h00000001 : 32'h00000000;
    s_nxt.ip_run   = ip_ex ? s_r.ip_run + 32'h00000001 : 32'h00000000;

    if (engage_button) begin
      s_nxt.eng_flag = 1'b1;
    end
    // Engagement sequence; a fault below overrides the next state it picks, but its engaged event still posts.
    case (s_r.st)
      ST_IDLE: begin
        if (s_r.eng_flag) begin
          s_nxt.st = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (engage_request && eng_ok) begin
          s_nxt.st = ST_ENGAGED;
          s_nxt.eng_flag = 1'b0;
          ev[EV_ENGAGED] = 1'b1;
        end
      end
      ST_ENGAGED: begin
        if (!engage_request) begin
          s_nxt.st = ST_IDLE;
        end
      end
      ST_SAFE: begin
        s_nxt.st = ST_SAFE;
      end
      default: begin
        s_nxt.st = ST_SAFE;
      end
    endcase
    if (ev[EV_SAFE]) begin
      s_nxt.st = ST_SAFE;
    end
    if (s_r.st == ST_SAFE) begin
      s_nxt.eng_flag = 1'b0;
    end

    // Register writes; a new event beats a write-one clear.
    if (wr) begin
      case (paddr)
        OFS_CTRL: s_nxt.eng_flag = s_nxt.eng_flag | pwdata[0];
        OFS_ENGAGE_LIMIT: s_nxt.eng_lim = pwdata[15:0];
        OFS_SENSOR_CFG: begin
          s_nxt.red_cfg = pwdata[7:0];
          s_nxt.if_type = pwdata[15:8];
        end
        OFS_CHAN_THR: s_nxt.chan_thr = pwdata[15:0];
        OFS_IPROC_CFG: begin
          s_nxt.ip_thr  = pwdata[15:0];
          s_nxt.ip_time = pwdata[23:16];
        end
        OFS_IRQ_STATUS: s_nxt.irq_sts = s_r.irq_sts & ~pwdata[7:0];
        OFS_IRQ_MASK: s_nxt.irq_msk = pwdata[7:0];
        // Unmapped writes change nothing.
        default: s_nxt.irq_msk = s_r.irq_msk;
      endcase
    end
    // Events go in after the clear, so a set in the same cycle wins.
    s_nxt.irq_sts = s_nxt.irq_sts | ev;

    // Read data is captured in the setup phase so it comes from a flip-flop.
    hit = 1'b1;
    s_nxt.rdata = '0;
    case (paddr)
      OFS_CTRL:         s_nxt.rdata = {31'h0, s_r.eng_flag};
      OFS_ENGAGE_LIMIT: s_nxt.rdata = {16'h0, s_r.eng_lim};
      OFS_SENSOR_CFG:   s_nxt.rdata = {16'h0, s_r.if_type, s_r.red_cfg};
      OFS_CHAN_THR:     s_nxt.rdata = {16'h0, s_r.chan_thr};
      OFS_IPROC_CFG:    s_nxt.rdata = {8'h0, s_r.ip_time, s_r.ip_thr};
      OFS_STATUS:       s_nxt.rdata = {22'h0, ang.out_range, ang.short_sup, ang.short_gnd,
                                        ip_ex, chan_ex, red_used, s_r.st, 2'b00};
      OFS_IRQ_STATUS:   s_nxt.rdata = {24'h0, s_r.irq_sts};
      OFS_IRQ_MASK:     s_nxt.rdata = {24'h0, s_r.irq_msk};
      OFS_ANGLE:        s_nxt.rdata = {ang.red_scaled, ang.prim_scaled};
      default:          hit = 1'b0;
    endcase
    // Outside a read setup the last read word stands.
    if (!rd) begin
      s_nxt.rdata = s_r.rdata;
    end
  end

  // One register for all state; reset loads the parameter defaults.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r          <= '0;
      s_r.st       <= ST_IDLE;
      s_r.eng_lim  <= ENGAGE_LIMIT_RST;
      s_r.red_cfg  <= REDUNDANT_RST;
      s_r.if_type  <= IFTYPE_RST;
      s_r.chan_thr <= CHAN_THR_RST;
      s_r.ip_thr   <= IPROC_THR_RST;
      s_r.ip_time  <= IPROC_TIME_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Zero wait states; the error flag is combinational on the address.
  assign pready        = 1'b1;
  assign pslverr       = acc && !hit;
  assign prdata        = s_r.rdata;
  // Engagement and safe state decode straight from the state register.
  assign steer_engaged = (s_r.st == ST_ENGAGED);
  assign safe_state    = (s_r.st == ST_SAFE);
  assign angle_out     = ang.prim_scaled;
  assign irq           = |(s_r.irq_sts & s_r.irq_msk);

  // ****************************************
  // Assertions
  // ****************************************
  // Checks on engagement, fault reaction and timer behaviour.
  a_engage_needs_flag: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(steer_engaged) |-> $past(s_r.eng_flag)) else $error("Engaged without engage flag.");
  a_engage_err_ok: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(steer_engaged) |-> $past(eng_ok)) else $error("Engaged with excess error.");
  a_short_trips: assert property (@(posedge pclk) disable iff (!presetn)
    (analogue && (ang.short_gnd || ang.short_sup)) |=> safe_state) else $error("Short not tripped.");
  a_chan_trip: assert property (@(posedge pclk) disable iff (!presetn)
    chan_trip |=> safe_state) else $error("Channel divergence not tripped.");
  a_single_skip: assert property (@(posedge pclk) disable iff (!presetn)
    !red_used |-> !chan_ex) else $error("Channel check with single sensor.");
  a_ip_timer: assert property (@(posedge pclk) disable iff (!presetn)
    ip_trip |-> s_r.ip_run >= 32'(s_r.ip_time) * 32'(TICK_CYC)) else $error("Peer trip too early.");
  a_timer_reset: assert property (@(posedge pclk) disable iff (!presetn)
    !chan_ex |=> s_r.chan_cnt == 8'h00) else $error("Channel timer not cleared.");
  a_plaus_safe: assert property (@(posedge pclk) disable iff (!presetn)
    plaus_fault |=> safe_state) else $error("Plausibility fault not tripped.");
  a_safe_latched: assert property (@(posedge pclk) disable iff (!presetn)
    safe_state |=> safe_state && !steer_engaged) else $error("Safe state left.");
  a_chan_persist: assert property (@(posedge pclk) disable iff (!presetn)
    chan_trip |-> s_r.chan_run >= 32'(CHAN_PERSIST_TICK * TICK_CYC)) else $error("Channel trip too early.");
  a_button_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (engage_button && s_r.st == ST_IDLE) |=> s_r.eng_flag) else $error("Button did not set flag.");
  a_event_wins: assert property (@(posedge pclk) disable iff (!presetn)
    ev[EV_SAFE] |=> s_r.irq_sts[EV_SAFE]) else $error("Safe event lost its status bit.");

  // Main scenarios to be seen in simulation.
  c_engage: cover property (@(posedge pclk) disable iff (!presetn) $rose(steer_engaged));
  c_chan_trip: cover property (@(posedge pclk) disable iff (!presetn) chan_trip);
  c_ip_trip: cover property (@(posedge pclk) disable iff (!presetn) ip_trip);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
endmodule
`default_nettype wire

// ### verification/angle_sensor_pair.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Dual analogue angle sensor pair model
// ****************************************
module angle_sensor_pair (
  input  wire logic               pclk,     // System clock.
  input  wire logic signed [15:0] angle,    // True angle, internal units.
  input  wire logic signed [15:0] skew,     // Extra error on redundant channel.
  input  wire logic [1:0]         fault,    // 1 gnd short, 2 supply short, 3 limits.
  output logic [12:0]             prim_mv,  // Primary output in mV.
  output logic [12:0]             red_mv    // Redundant output in mV.
);
  logic signed [15:0] p;
  logic signed [15:0] r;
  function automatic logic signed [15:0] lim(input logic signed [15:0] v);
    return v < 16'sh01F4 ? 16'sh01F4 : (v > 16'sh1194 ? 16'sh1194 : v);
  endfunction
  // inverted characteristics, so a shared supply fault moves the two apart.
  always_comb begin
    p = lim(16'sh09C4 + angle);
    r = lim(16'sh09C4 - angle - skew);
  end
  // Outputs change just after the edge; shorts sit one millivolt past the limits, code 3 sits exactly on them.
  always_ff @(posedge pclk) begin
    prim_mv <= (fault == 2'h1) ? 13'h0063 : (fault == 2'h3) ? 13'h0064 : p[12:0];
    red_mv  <= (fault == 2'h2) ? 13'h1325 : (fault == 2'h3) ? 13'h1324 : r[12:0];
  end
endmodule
`default_nettype wire

// ### verification/steer_angle_safety_monitor_tb.sv
`timescale 1ns/1ps
`default_nettype none
module steer_angle_safety_monitor_tb;
  import angle_mon_pkg::*;
  localparam int unsigned T = 20;
  logic               pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0, prdata, q;
  logic               pready, pslverr, e, steer_engaged, safe_state, irq;
  logic [12:0]        prim_mv, red_mv;
  logic signed [15:0] angle = 0, skew = 0;
  logic [15:0]        peer_angle = 16'h0, angle_setpoint = 16'h0, angle_out;
  logic [1:0]         fault = 2'h0;
  logic               engage_button = 0, engage_request = 0, plaus_fault = 0;
  int                 bad_count = 0, total_checks = 0;
  // ****************************************
  // Design, sensor model and clock
  // ****************************************
  angle_monitor #(.TICK_CYC(T)) u_angle_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .prim_mv(prim_mv), .red_mv(red_mv), .peer_angle(peer_angle),
    .engage_button(engage_button), .engage_request(engage_request), .angle_setpoint(angle_setpoint),
    .plaus_fault(plaus_fault), .steer_engaged(steer_engaged), .safe_state(safe_state),
    .angle_out(angle_out), .irq(irq));
  angle_sensor_pair u_angle_sensor_pair (.pclk(pclk), .angle(angle), .skew(skew), .fault(fault),
    .prim_mv(prim_mv), .red_mv(red_mv));
  // Free running 125 MHz clock.
  always #4 pclk = ~pclk;
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic conclude();
    if (bad_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Read data stays put until the next read setup, so taking it at the wake-up is safe.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rst();
    @(posedge pclk);
    presetn <= 0;
    {angle, skew, fault, peer_angle, angle_setpoint} <= '0;
    {engage_button, engage_request, plaus_fault} <= '0;
    repeat (5) @(posedge pclk);
    presetn <= 1;
    repeat (10) @(posedge pclk);
  endtask
  task automatic press();
    @(posedge pclk) engage_button <= 1;
    @(posedge pclk) engage_button <= 0;
  endtask
  // Safe state must arrive no sooner than lo and no later than hi cycles.
  task automatic wsafe(input int lo, input int hi);
    int n;
    n = 0;
    while (safe_state !== 1'b1 && n < hi) begin
      @(posedge pclk);
      n++;
    end
    chk("safe_timing", 1, {31'h0, n >= lo && safe_state === 1'b1});
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_defaults();
    apb(OFS_ENGAGE_LIMIT, 0, 0); chk("engage_limit", 32'h00000064, q);
    apb(OFS_SENSOR_CFG, 0, 0); chk("sensor_cfg", 32'h000000FF, q);
    apb(OFS_CHAN_THR, 0, 0); chk("chan_thr", 32'h00000064, q);
    apb(OFS_IPROC_CFG, 0, 0); chk("iproc_cfg", 32'h000A0064, q);
    apb(OFS_IRQ_MASK, 0, 0); chk("irq_mask", 32'h0, q);
    apb(8'h24, 0, 0); chk("unmapped_err", 1, e); chk("unmapped_data", 32'h0, q);
  endtask
  task automatic t_engage();
    @(posedge pclk) engage_request <= 1;
    angle_setpoint <= 16'h0065;
    press();
    repeat (5) @(posedge pclk); chk("engaged_err101", 0, steer_engaged);
    angle_setpoint <= 16'hFF9C;
    repeat (4) @(posedge pclk); chk("engaged_err100", 1, steer_engaged);
    apb(OFS_IRQ_STATUS, 0, 0); chk("ev_engaged", 1, q[EV_ENGAGED]); chk("irq_masked", 0, irq);
    apb(OFS_IRQ_MASK, 1, 32'h00000040); @(posedge pclk); chk("irq_on", 1, irq);
    apb(OFS_IRQ_STATUS, 1, 32'h00000040); @(posedge pclk); chk("irq_cleared", 0, irq);
    engage_request <= 0;
    repeat (3) @(posedge pclk); chk("released", 0, steer_engaged);
    engage_request <= 1;
    repeat (6) @(posedge pclk); chk("no_flag", 0, steer_engaged);
    apb(OFS_CTRL, 1, 32'h00000001); repeat (3) @(posedge pclk); chk("ctrl_flag", 1, steer_engaged);
    apb(OFS_STATUS, 0, 0); chk("status", 32'h0000001C, q);
    engage_request <= 0;
  endtask
  task automatic t_chan();
    rst();
    skew <= 16'sh0064;
    repeat (300) @(posedge pclk); chk("chan_at_thr", 0, safe_state);
    skew <= 16'sh0096;
    repeat (180) @(posedge pclk);
    skew <= 0;
    repeat (20) @(posedge pclk);
    skew <= 16'sh0096;
    repeat (180) @(posedge pclk); chk("chan_restart", 0, safe_state);
    skew <= 0;
    repeat (20) @(posedge pclk);
    skew <= 16'sh0065;
    wsafe(200, 280);
    skew <= 0;
    engage_request <= 1;
    press();
    repeat (10) @(posedge pclk); chk("safe_latched", 1, safe_state);
    chk("engage_blocked", 0, steer_engaged);
    apb(OFS_IRQ_STATUS, 0, 0); chk("ev_chan", 1, q[EV_CHAN_DIV]); chk("ev_safe", 1, q[EV_SAFE]);
  endtask
  task automatic t_single();
    rst();
    apb(OFS_SENSOR_CFG, 1, 32'h0);
    skew <= 16'sh01F4;
    repeat (400) @(posedge pclk); chk("single_no_chan", 0, safe_state);
    skew <= 0;
    apb(OFS_SENSOR_CFG, 1, 32'h000001FF);
    fault <= 2'h1;
    repeat (50) @(posedge pclk); chk("iftype_off", 0, safe_state);
  endtask
  task automatic t_peer();
    rst();
    apb(OFS_IPROC_CFG, 1, 32'h00030064);
    peer_angle <= 16'h0064;
    repeat (150) @(posedge pclk); chk("peer_at_thr", 0, safe_state);
    peer_angle <= 16'hFF9B;
    wsafe(60, 120);
  endtask
  task automatic t_shorts();
    rst();
    fault <= 2'h3;
    repeat (20) @(posedge pclk); chk("short_edge", 0, safe_state);
    for (int i = 1; i < 3; i++) begin
      rst();
      fault <= i[1:0];
      wsafe(1, 12);
      apb(OFS_IRQ_STATUS, 0, 0); chk("ev_short", 1, q[i-1]);
    end
  endtask
  task automatic t_plaus();
    rst();
    plaus_fault <= 1;
    @(posedge pclk) plaus_fault <= 0;
    wsafe(0, 5);
    repeat (5) @(posedge pclk); chk("plaus_latched", 1, safe_state);
  endtask
  task automatic t_scale();
    rst();
    angle <= 16'sh012C;
    peer_angle <= 16'h012C;
    repeat (10) @(posedge pclk); chk("angle_out", 32'h0000012C, {16'h0, angle_out});
    apb(OFS_ANGLE, 0, 0); chk("angles", 32'h012C012C, q);
  endtask
  // Main sequence.
  initial begin
    rst();
    t_defaults();
    t_engage();
    t_chan();
    t_single();
    t_peer();
    t_shorts();
    t_plaus();
    t_scale();
    conclude();
  end
  // Watchdog, well beyond the few thousand cycles the scenarios need.
  initial begin
    repeat (30000) @(posedge pclk);
    bad_count++;
    conclude();
  end
endmodule
`default_nettype wire
